// file: dv/scd_prom_switch_model.sv
// scd_prom_switch_model: configuration prom and dip switch bank facing the decoder
// assumes: bench gives the bank as closed = 1 and may ask for contact chatter
`timescale 1ns/1ps
module scd_prom_switch_model import scd_pkg::*; #(
    parameter scd_rec_t REC = '0
) (
    // clock
    input wire logic pclk,
    // bench side
    input wire scd_sw_t sw_closed,
    input wire logic chatter,
    // switch pins
    output logic cfg_ptr_lsb_switch_n,
    output logic [5:0] cfg_ptr_mid_switches_n,
    output logic cfg_ptr_msb_switch_n,
    output logic scsi_id_bit2_switch_n,
    output logic scsi_id_bit1_switch_n,
    output logic scsi_id_bit0_switch_n,
    output logic hard_reset_switch_n,
    output logic auto_seek_switch_n,
    output logic powerup_write_lock_switch_n,
    // prom
    input wire logic [7:0] cfg_prom_addr,
    output logic [31:0] cfg_prom_data
);
    logic bounce_reg = 1'b0;

    // chatter flips the lsb contact every cycle, so the filter never sees it settle
    always_ff @(posedge pclk) begin
        bounce_reg <= chatter ? ~bounce_reg : 1'b0;
    end

    // a closed contact pulls its pin low
    assign cfg_ptr_lsb_switch_n = ~sw_closed.ptr[0] ^ bounce_reg;
    assign cfg_ptr_mid_switches_n = ~sw_closed.ptr[6:1];
    assign cfg_ptr_msb_switch_n = ~sw_closed.ptr[7];
    assign scsi_id_bit2_switch_n = ~sw_closed.scsi_id[2];
    assign scsi_id_bit1_switch_n = ~sw_closed.scsi_id[1];
    assign scsi_id_bit0_switch_n = ~sw_closed.scsi_id[0];
    assign hard_reset_switch_n = ~sw_closed.hard_reset;
    assign auto_seek_switch_n = ~sw_closed.auto_seek;
    assign powerup_write_lock_switch_n = ~sw_closed.wlock;

    // one populated record; empty slots read a pattern that moves with the address
    assign cfg_prom_data = (cfg_prom_addr == CFG_PTR_ONLY) ? 32'(REC) : {4{~cfg_prom_addr}};
endmodule

// file: dv/scd_switch_config_decoder_tb.sv
// scd_switch_config_decoder_tb: directed scenarios for the switch config decoder
// assumes: the prom/switch model stands at the far side; assertions live in the design
`timescale 1ns/1ps
module scd_switch_config_decoder_tb import scd_pkg::*; ;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int DEB = 8;
    localparam scd_rec_t EXP_REC = '{capacity: 22'h0A1B2C, blk_size: 2'h2, blk_size_vld: 1'b1,
        drv_type: 1'b1, drv_addr: 3'h5, fmt_addr: 3'h3};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wr_req = 1'b0, cmd_valid = 1'b0, cmd_rw = 1'b0;
    logic hdr_trk = 1'b0, chatter = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, cfg_prom_data, rd;
    logic pready, pslverr, cpu_halt, selftest_busy, cfg_valid, wr_grant, wr_refuse, seek_start, seek_trk;
    logic [1:0] wr_drive = 2'h0;
    logic [8:0] hdr_cyl = 9'h000, seek_cyl;
    logic [7:0] cfg_prom_addr;
    logic [2:0] scsi_id;
    logic cfg_ptr_lsb_switch_n, cfg_ptr_msb_switch_n, scsi_id_bit2_switch_n, scsi_id_bit1_switch_n;
    logic scsi_id_bit0_switch_n, hard_reset_switch_n, auto_seek_switch_n, powerup_write_lock_switch_n;
    logic [5:0] cfg_ptr_mid_switches_n;
    scd_rec_t cfg_rec;
    scd_sw_t sw = '0;
    int n_fail = 0;
    int n_compared = 0;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    scd_switch_config_decoder #(.DEB_CYCLES(DEB)) scd_switch_config_decoder_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cfg_ptr_lsb_switch_n, .cfg_ptr_mid_switches_n, .cfg_ptr_msb_switch_n, .scsi_id_bit2_switch_n,
        .scsi_id_bit1_switch_n, .scsi_id_bit0_switch_n, .hard_reset_switch_n, .auto_seek_switch_n,
        .powerup_write_lock_switch_n, .cfg_prom_addr, .cfg_prom_data, .cpu_halt, .selftest_busy, .cfg_rec,
        .cfg_valid, .scsi_id, .wr_req, .wr_drive, .wr_grant, .wr_refuse, .cmd_valid, .cmd_rw, .hdr_cyl,
        .hdr_trk, .seek_start, .seek_cyl, .seek_trk);

    scd_prom_switch_model #(.REC(EXP_REC)) scd_prom_switch_model_i (
        .pclk, .sw_closed(sw), .chatter, .cfg_ptr_lsb_switch_n, .cfg_ptr_mid_switches_n,
        .cfg_ptr_msb_switch_n, .scsi_id_bit2_switch_n, .scsi_id_bit1_switch_n, .scsi_id_bit0_switch_n,
        .hard_reset_switch_n, .auto_seek_switch_n, .powerup_write_lock_switch_n, .cfg_prom_addr,
        .cfg_prom_data);

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("counts: %0d compared, %0d failed", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // a wait that runs dry counts as a mismatch and ends the run
    task automatic timeout(input string what);
        n_fail++;
        $display("Error at %0t: no %s in time", $time, what);
        finish_test();
    endtask

    // apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timeout("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // waits out the self-test, measures it, then lets load and fetch pass
    task automatic wait_test();
        int i;
        int n;
        for (i = 0; i < 500; i++) begin
            @(posedge pclk);
            #1;
            if (selftest_busy === 1'b1) break;
        end
        if (i == 500) timeout("self-test");
        for (n = 1; n < 1000; n++) begin
            @(posedge pclk);
            #1;
            if (selftest_busy !== 1'b1) break;
        end
        chk(n, TEST_CYCLES, "self-test length");
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic boot(input scd_sw_t s);
        @(posedge pclk);
        presetn <= 1'b0;
        sw <= s;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_test();
    endtask

    task automatic wr(input logic [1:0] d, input logic [1:0] exp);
        @(posedge pclk);
        wr_req <= 1'b1;
        wr_drive <= d;
        @(posedge pclk);
        wr_req <= 1'b0;
        #1;
        chk(32'({wr_grant, wr_refuse}), 32'(exp), "write grant/refuse");
    endtask

    task automatic cmd(input logic [8:0] c, input logic t, input logic rw, input logic exp);
        @(posedge pclk);
        cmd_valid <= 1'b1;
        cmd_rw <= rw;
        hdr_cyl <= c;
        hdr_trk <= t;
        @(posedge pclk);
        cmd_valid <= 1'b0;
        #1;
        chk(32'(seek_start), 32'(exp), "seek pulse");
        if (exp) chk(32'({seek_cyl, seek_trk}), 32'({c, t}), "seek address");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_boot();
        @(posedge pclk);
        sw <= '{ptr: 8'hFF, scsi_id: 3'h5, default: 1'b0};
        chatter <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        chatter <= 1'b0;
        repeat (DEB - 1) @(posedge pclk);
        #1;
        chk(32'(cpu_halt), 32'h1, "halted while settling");
        chk(32'(selftest_busy), 32'h0, "no test before bank settles");
        wait_test();
        chk(32'(cfg_prom_addr), 32'h0000_00FF, "all-closed pointer");
        chk(32'(cfg_valid), 32'h1, "valid selection");
        chk(32'(cfg_rec), 32'(EXP_REC), "record fields");
        chk(32'(scsi_id), 32'h5, "identity");
        apb(1'b0, CFG_PTR_OFS, 32'h0);
        chk(rd, 32'h0000_00FF, "pointer register");
        apb(1'b0, CFG_REC_OFS, 32'h0);
        chk(rd, 32'(EXP_REC), "record register");
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(32'({rd[10:8], rd[3:0]}), 32'h5C, "status id and run");
        $display("boot test done");
    endtask

    task automatic t_ptr();
        logic [7:0] ptrs [5] = '{8'h01, 8'h80, 8'h02, 8'h40, 8'h7E};
        logic [2:0] ids [5] = '{3'h0, 3'h7, 3'h1, 3'h4, 3'h2};
        for (int k = 0; k < 5; k++) begin
            boot('{ptr: ptrs[k], scsi_id: ids[k], default: 1'b0});
            chk(32'(cfg_prom_addr), 32'(ptrs[k]), "pointer bit order");
            chk(32'(cfg_valid), 32'h0, "other pointer invalid");
            chk(32'(scsi_id), 32'(ids[k]), "identity bits");
        end
        $display("pointer test done");
    endtask

    task automatic t_lock();
        boot('{ptr: 8'hFF, wlock: 1'b1, default: 1'b0});
        apb(1'b0, WLOCK_OFS, 32'h0);
        chk(rd, 32'(LOCK_ALL), "power-up lock");
        wr(2'h2, 2'b01);
        apb(1'b1, XCMD_OFS, 32'h0000_0001);
        apb(1'b0, WLOCK_OFS, 32'h0);
        chk(rd, 32'(LOCK_ALL), "other function ignored");
        apb(1'b1, XCMD_OFS, 32'h0000_0500);
        apb(1'b0, WLOCK_OFS, 32'h0);
        chk(rd, 32'h5, "selective lock");
        wr(2'h1, 2'b10);
        wr(2'h0, 2'b01);
        apb(1'b0, 8'h40, 32'h0);
        chk(32'(err), 32'h1, "unmapped address error");
        $display("lock test done");
    endtask

    task automatic t_seek();
        cmd(9'h1A5, 1'b1, 1'b1, 1'b0);
        @(posedge pclk);
        sw <= '{ptr: 8'h00, scsi_id: 3'h6, auto_seek: 1'b1, wlock: 1'b1, default: 1'b0};
        repeat (DEB + 6) @(posedge pclk);
        cmd(9'h0C3, 1'b1, 1'b1, 1'b1);
        cmd(9'h15A, 1'b0, 1'b1, 1'b1);
        cmd(9'h0F0, 1'b1, 1'b0, 1'b0);
        chk(32'({cfg_prom_addr, scsi_id}), 32'({8'hFF, 3'h0}), "no reload in run");
        apb(1'b0, WLOCK_OFS, 32'h0);
        chk(rd, 32'h5, "locks kept in run");
        $display("seek test done");
    endtask

    task automatic t_hard();
        @(posedge pclk);
        sw <= '{ptr: 8'hFF, scsi_id: 3'h3, hard_reset: 1'b1, default: 1'b0};
        repeat (DEB + 6) @(posedge pclk);
        #1;
        chk(32'({cpu_halt, cfg_valid, selftest_busy}), 32'h4, "halted and cleared");
        wr(2'h1, 2'b00);
        cmd(9'h011, 1'b0, 1'b1, 1'b0);
        apb(1'b0, WLOCK_OFS, 32'h0);
        chk(rd, 32'(LOCK_NONE), "locks cleared");
        @(posedge pclk);
        sw <= '{ptr: 8'hFF, scsi_id: 3'h3, default: 1'b0};
        wait_test();
        chk(32'({cfg_prom_addr, scsi_id, cfg_valid}), 32'({8'hFF, 3'h3, 1'b1}), "reload");
        wr(2'h3, 2'b10);
        $display("hard reset test done");
    endtask

    // main sequence
    initial begin
        t_boot();
        t_ptr();
        t_lock();
        t_seek();
        t_hard();
        finish_test();
    end
endmodule

// file: logic/scd_pkg.sv
// scd_pkg: constants, register map and carrier types for the switch config decoder
// assumes: one 100 MHz clock, APB register access, switch closed pulls the pin low
package scd_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int DEB_TIME_US = 5000;                   // switch bounce settle time
    localparam int DEB_CYCLES_DEF = DEB_TIME_US * CLK_MHZ;
    localparam int TEST_TIME_US = 2;                     // self-test run time
    localparam int TEST_CYCLES = TEST_TIME_US * CLK_MHZ;
    localparam int CNT_W = 20;

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_PTR_ONLY = 8'hFF;         // all eight selectors closed
    localparam int NUM_DRV = 4;
    localparam logic [NUM_DRV-1:0] LOCK_ALL = 4'hF;
    localparam logic [NUM_DRV-1:0] LOCK_NONE = 4'h0;
    localparam logic [3:0] XCMD_WSR = 4'h0;              // write switch register function

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CFG_PTR_OFS = 8'h04;
    localparam logic [7:0] CFG_REC_OFS = 8'h08;
    localparam logic [7:0] WLOCK_OFS = 8'h0C;
    localparam logic [7:0] XCMD_OFS = 8'h10;
    localparam int XCMD_FUNC_LSB = 0;
    localparam int XCMD_MASK_LSB = 8;
    localparam int STAT_ID_LSB = 8;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // switch bank, 1 = closed
    typedef struct packed {
        logic hard_reset;
        logic auto_seek;
        logic wlock;
        logic [2:0] scsi_id;
        logic [7:0] ptr;
    } scd_sw_t;

    // configuration record as read from the prom
    typedef struct packed {
        logic [21:0] capacity;
        logic [1:0] blk_size;
        logic blk_size_vld;
        logic drv_type;
        logic [2:0] drv_addr;
        logic [2:0] fmt_addr;
    } scd_rec_t;

    typedef enum logic [2:0] {ST_SETTLE, ST_HALT, ST_TEST, ST_LOAD, ST_FETCH, ST_RUN} scd_state_t;
endpackage

// file: logic/scd_switch_config_decoder.sv
// scd_switch_config_decoder: samples the switch bank, runs reset and self-test,
// fetches the config record and keeps per-drive write locks
// assumes: prom data valid in the cycle after the address changes; switch pins are raw
`timescale 1ns/1ps
module scd_switch_config_decoder import scd_pkg::*; #(
    parameter int DEB_CYCLES = DEB_CYCLES_DEF
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // switch pins, low = closed
    input wire logic cfg_ptr_lsb_switch_n,
    input wire logic [5:0] cfg_ptr_mid_switches_n,
    input wire logic cfg_ptr_msb_switch_n,
    input wire logic scsi_id_bit2_switch_n,
    input wire logic scsi_id_bit1_switch_n,
    input wire logic scsi_id_bit0_switch_n,
    input wire logic hard_reset_switch_n,
    input wire logic auto_seek_switch_n,
    input wire logic powerup_write_lock_switch_n,
    // configuration prom
    output logic [7:0] cfg_prom_addr,
    input wire logic [31:0] cfg_prom_data,
    // controller core
    output logic cpu_halt,
    output logic selftest_busy,
    output scd_rec_t cfg_rec,
    output logic cfg_valid,
    output logic [2:0] scsi_id,
    // write requests from the core
    input wire logic wr_req,
    input wire logic [1:0] wr_drive,
    output logic wr_grant,
    output logic wr_refuse,
    // read/write command header
    input wire logic cmd_valid,
    input wire logic cmd_rw,
    input wire logic [8:0] hdr_cyl,
    input wire logic hdr_trk,
    output logic seek_start,
    output logic [8:0] seek_cyl,
    output logic seek_trk
);
    localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_CYCLES - 1);
    localparam logic [CNT_W-1:0] TEST_LAST = CNT_W'(TEST_CYCLES - 1);
    // ------------------------------------------------------------
    // switch sampling and bounce filter
    // ------------------------------------------------------------
    scd_sw_t raw, s1_reg, s2_reg, last_reg, last_next, filt_reg, filt_next;
    logic [CNT_W-1:0] deb_cnt_reg, deb_cnt_next;
    logic deb_ok_reg, deb_ok_next;
    // pins are inverted so closed reads as one
    assign raw.ptr = ~{cfg_ptr_msb_switch_n, cfg_ptr_mid_switches_n, cfg_ptr_lsb_switch_n};
    assign raw.scsi_id = ~{scsi_id_bit2_switch_n, scsi_id_bit1_switch_n, scsi_id_bit0_switch_n};
    assign raw.hard_reset = ~hard_reset_switch_n;
    assign raw.auto_seek = ~auto_seek_switch_n;
    assign raw.wlock = ~powerup_write_lock_switch_n;
    // whole bank must hold still for the settle time; one counter is cheaper than fourteen
    always_comb begin
        last_next = s2_reg;
        filt_next = filt_reg;
        deb_ok_next = deb_ok_reg;
        deb_cnt_next = '0;
        if (s2_reg == last_reg) begin
            deb_cnt_next = deb_cnt_reg;
            if (deb_cnt_reg == DEB_LAST) begin
                filt_next = last_reg;
                deb_ok_next = 1'b1;
            end else begin
                deb_cnt_next = deb_cnt_reg + 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            last_reg <= '0;
            filt_reg <= '0;
            deb_cnt_reg <= '0;
            deb_ok_reg <= 1'b0;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            last_reg <= last_next;
            filt_reg <= filt_next;
            deb_cnt_reg <= deb_cnt_next;
            deb_ok_reg <= deb_ok_next;
        end
    end
    // ------------------------------------------------------------
    // sequencer, configuration, locks and core-facing outputs
    // ------------------------------------------------------------
    scd_state_t st_reg, st_next;
    logic [CNT_W-1:0] tcnt_reg, tcnt_next;
    logic [7:0] ptr_reg, ptr_next;
    logic [2:0] id_reg, id_next;
    logic pwl_reg, pwl_next, vld_reg, vld_next;
    scd_rec_t rec_reg, rec_next;
    logic [NUM_DRV-1:0] lock_reg, lock_next;
    logic grant_reg, grant_next, refuse_reg, refuse_next, halt_reg, halt_next, busy_reg, busy_next;
    logic seek_reg, seek_next, strk_reg, strk_next;
    logic [8:0] scyl_reg, scyl_next;
    logic xcmd_wr;
    logic [31:0] xcmd_data;
    always_comb begin
        st_next = st_reg;
        tcnt_next = '0;
        ptr_next = ptr_reg;
        id_next = id_reg;
        pwl_next = pwl_reg;
        vld_next = vld_reg;
        rec_next = rec_reg;
        lock_next = lock_reg;
        grant_next = 1'b0;
        refuse_next = 1'b0;
        seek_next = 1'b0;
        scyl_next = scyl_reg;
        strk_next = strk_reg;
        case (st_reg)
            ST_SETTLE: begin
                if (deb_ok_reg) begin
                    st_next = filt_reg.hard_reset ? ST_HALT : ST_TEST;
                end
            end
            ST_HALT: begin
                // hold everything at its initial value while the switch is closed
                ptr_next = '0;
                id_next = '0;
                pwl_next = 1'b0;
                vld_next = 1'b0;
                rec_next = '0;
                lock_next = LOCK_NONE;
                scyl_next = '0;
                strk_next = 1'b0;
                if (!filt_reg.hard_reset) begin
                    st_next = ST_TEST;
                end
            end
            ST_TEST: begin
                tcnt_next = tcnt_reg + 1'b1;
                if (filt_reg.hard_reset) begin
                    st_next = ST_HALT;
                end else if (tcnt_reg == TEST_LAST) begin
                    st_next = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // one-time capture; later switch moves are ignored until next reset
                ptr_next = filt_reg.ptr;
                id_next = filt_reg.scsi_id;
                pwl_next = filt_reg.wlock;
                lock_next = filt_reg.wlock ? LOCK_ALL : LOCK_NONE;
                st_next = ST_FETCH;
            end
            ST_FETCH: begin
                rec_next = scd_rec_t'(cfg_prom_data);
                vld_next = (ptr_reg == CFG_PTR_ONLY);
                st_next = ST_RUN;
            end
            ST_RUN: begin
                if (filt_reg.hard_reset) begin
                    st_next = ST_HALT;
                end
                if (wr_req) begin
                    refuse_next = lock_reg[wr_drive];
                    grant_next = ~lock_reg[wr_drive];
                end
                // auto-seek is read live, as is hard reset; the other switches are frozen at load
                if (cmd_valid && cmd_rw && filt_reg.auto_seek) begin
                    seek_next = 1'b1;
                    scyl_next = hdr_cyl;
                    strk_next = hdr_trk;
                end
                if (xcmd_wr && xcmd_data[XCMD_FUNC_LSB +: 4] == XCMD_WSR) begin
                    lock_next = xcmd_data[XCMD_MASK_LSB +: NUM_DRV];
                end
            end
            default: begin
                st_next = ST_SETTLE;
            end
        endcase
        halt_next = (st_next == ST_HALT) || (st_next == ST_SETTLE);
        busy_next = (st_next == ST_TEST);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_SETTLE;
            tcnt_reg <= '0;
            ptr_reg <= '0;
            id_reg <= '0;
            pwl_reg <= 1'b0;
            vld_reg <= 1'b0;
            rec_reg <= '0;
            lock_reg <= LOCK_NONE;
            grant_reg <= 1'b0;
            refuse_reg <= 1'b0;
            seek_reg <= 1'b0;
            scyl_reg <= '0;
            strk_reg <= 1'b0;
            halt_reg <= 1'b1;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tcnt_reg <= tcnt_next;
            ptr_reg <= ptr_next;
            id_reg <= id_next;
            pwl_reg <= pwl_next;
            vld_reg <= vld_next;
            rec_reg <= rec_next;
            lock_reg <= lock_next;
            grant_reg <= grant_next;
            refuse_reg <= refuse_next;
            seek_reg <= seek_next;
            scyl_reg <= scyl_next;
            strk_reg <= strk_next;
            halt_reg <= halt_next;
            busy_reg <= busy_next;
        end
    end
    // halt and busy leave flops, decoded one state ahead so they track st_reg
    assign cpu_halt = halt_reg;
    assign selftest_busy = busy_reg;
    assign cfg_prom_addr = ptr_reg;
    assign cfg_rec = rec_reg;
    assign cfg_valid = vld_reg;
    assign scsi_id = id_reg;
    assign wr_grant = grant_reg;
    assign wr_refuse = refuse_reg;
    assign seek_start = seek_reg;
    assign seek_cyl = scyl_reg;
    assign seek_trk = strk_reg;
    // ------------------------------------------------------------
    // apb slave, one wait-free access phase
    // ------------------------------------------------------------
    logic [31:0] rdata_reg, rdata_next;
    logic rdy_reg, rdy_next, err_reg, err_next;
    logic [31:0] status;
    assign status = {21'h0, id_reg, 1'b0, pwl_reg, filt_reg.auto_seek, ~vld_reg, vld_reg,
                     st_reg == ST_RUN, selftest_busy, cpu_halt};
    assign xcmd_wr = psel && penable && rdy_reg && pwrite && paddr == XCMD_OFS;
    assign xcmd_data = pwdata;
    // answer decoded in setup so pready and prdata come from flops
    always_comb begin
        rdy_next = psel && !penable;
        rdata_next = '0;
        err_next = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                STATUS_OFS: rdata_next = status;
                CFG_PTR_OFS: rdata_next = {24'h0, ptr_reg};
                CFG_REC_OFS: rdata_next = rec_reg;
                WLOCK_OFS: rdata_next = {28'h0, lock_reg};
                XCMD_OFS: rdata_next = '0;
                default: err_next = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_reg <= '0;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            rdy_reg <= rdy_next;
            err_reg <= err_next;
        end
    end
    assign prdata = rdata_reg;
    assign pready = rdy_reg;
    assign pslverr = err_reg;
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_ptr_load: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_LOAD |=> ptr_reg == $past(filt_reg.ptr)) else $error("pointer not loaded from switches");
    chk_valid_ff: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_RUN |-> vld_reg == (ptr_reg == 8'hFF)) else $error("config valid wrong");
    chk_rec_take: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_FETCH |=> rec_reg == $past(cfg_prom_data)) else $error("record not taken");
    chk_id_map: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_LOAD |=> scsi_id == $past(filt_reg.scsi_id)) else $error("scsi id mismatch");
    chk_halt_init: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_HALT ##1 st_reg == ST_HALT |-> cpu_halt && lock_reg == 4'h0 && !vld_reg
        && !wr_grant) else $error("not initialised while halted");
    chk_test_after: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_HALT && !filt_reg.hard_reset |=> selftest_busy) else $error("no self-test");
    chk_seek_fire: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_RUN && cmd_valid && cmd_rw && filt_reg.auto_seek && !filt_reg.hard_reset
        |=> seek_start && seek_cyl == $past(hdr_cyl)) else $error("auto seek missing");
    chk_pwr_lock: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_LOAD && filt_reg.wlock |=> lock_reg == 4'hF) else $error("power-up lock missed");
    chk_wr_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_RUN && wr_req && lock_reg[wr_drive] |=> wr_refuse && !wr_grant)
        else $error("locked drive written");
    chk_xcmd_lock: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_RUN && xcmd_wr && pwdata[3:0] == 4'h0 && !filt_reg.hard_reset
        |=> lock_reg == $past(pwdata[11:8])) else $error("selective lock failed");
    chk_sync_path: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(filt_reg) |-> $past(s2_reg) == $past(last_reg)) else $error("unfiltered switch change");
    chk_no_reload: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_RUN && $past(st_reg) == ST_RUN |-> $stable(ptr_reg) && $stable(scsi_id))
        else $error("config reloaded in operation");
    cov_run: cover property (@(posedge pclk) disable iff (!presetn) st_reg == ST_RUN && vld_reg);
    cov_switch_reset: cover property (@(posedge pclk) disable iff (!presetn)
        st_reg == ST_HALT ##1 st_reg == ST_TEST);
    cov_refuse: cover property (@(posedge pclk) disable iff (!presetn) wr_refuse);
    cov_seek: cover property (@(posedge pclk) disable iff (!presetn) seek_start);
endmodule
